/* bru_top.sv */
// byte rotate unit: instruction sequencer, file memory, bus slave
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module bru_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import bru_pkg::*;
    // ************************************************************
    // declarations
    // ************************************************************
    logic aw_full_ff, nxt_aw_full, w_full_ff, nxt_w_full;
    logic [7:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    bru_state_t state_ff, nxt_state;
    logic ext_en_ff, nxt_ext_en, illegal_ff, nxt_illegal;
    logic [15:0] instr_ff, nxt_instr;
    logic [7:0] wreg_ff, nxt_wreg;
    logic [7:0] status_ff, nxt_status;
    logic [3:0] bank_ff, nxt_bank;
    logic [11:0] base_ff, nxt_base;
    logic [11:0] faddr_ff, nxt_faddr;
    logic left_ff, nxt_left, dest_ff, nxt_dest;
    logic [11:0] phys_ff, nxt_phys;
    logic [7:0] operand_ff, nxt_operand;
    logic [7:0] result_ff, nxt_result;
    logic [7:0] file_mem [FILE_DEPTH];
    logic mem_we, do_write, busy, rd_hit;
    logic [11:0] mem_waddr, dec_phys;
    logic [7:0] mem_wdata, rot_result;
    logic [31:0] wr_merged, rd_value;
    logic rot_carry, rot_neg, rot_zero;
    // ************************************************************
    // helpers
    // ************************************************************
    // byte lanes left out by the write strobes are written as zero; wreg, status and file data skip the write if lane 0 is off;
    // all registers sit in the low lanes, so full strobes are the norm
    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign wr_merged[i*8 +: 8] = wstrb_ff[i] ? wdata_ff[i*8 +: 8] : 8'h00;
    end
    // ************************************************************
    // submodules
    // ************************************************************
    // 8-bit file field, single d and a bits
    bru_addr u_addr (
        .acc_n(instr_ff[ACC_BIT]),
        .file_addr(instr_ff[7:0]),
        .bank_select_register(bank_ff),
        .ext_en(ext_en_ff),
        .index_base(base_ff),
        .phys_addr(dec_phys),
        .indexed()
    );
    bru_rotate u_rotate (
        .op_left(left_ff),
        .operand(operand_ff),
        .carry_in(status_ff[STAT_C_BIT]),
        .result(rot_result),
        .carry_out(rot_carry),
        .neg(rot_neg),
        .zero(rot_zero)
    );
    // ************************************************************
    // bus handshakes
    // ************************************************************
    // a pending response blocks new writes, so at most one is in flight
    assign busy = (state_ff != ST_IDLE);
    assign s_axi_awready = !aw_full_ff && !bvalid_ff;
    assign s_axi_wready = !w_full_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign do_write = aw_full_ff && w_full_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    // read mux; unmapped offsets return zero and an error answer
    always_comb begin
        rd_value = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            OFS_CTRL: rd_value[CTRL_EXT_BIT] = ext_en_ff;
            OFS_INSTR: rd_value[15:0] = instr_ff;
            OFS_WREG: rd_value[7:0] = wreg_ff;
            OFS_STATUS: rd_value[7:0] = status_ff;
            OFS_BANK: rd_value[3:0] = bank_ff;
            OFS_INDEX_BASE: rd_value[11:0] = base_ff;
            OFS_FILE_ADDR: rd_value[11:0] = faddr_ff;
            OFS_FILE_DATA: rd_value[7:0] = file_mem[faddr_ff];
            OFS_STATE: begin
                rd_value[STATE_BUSY_BIT] = busy;
                rd_value[STATE_ILL_BIT] = illegal_ff;
                rd_value[STATE_PHASE_LSB +: 3] = state_ff;
            end
            default: rd_hit = 1'b0;
        endcase
    end
    // ************************************************************
    // bus channel state
    // ************************************************************
    always_comb begin
        nxt_aw_full = aw_full_ff;
        nxt_awaddr = awaddr_ff;
        nxt_w_full = w_full_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        // address and data are taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw_full = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w_full = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (do_write) begin
            nxt_aw_full = 1'b0;
            nxt_w_full = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = (awaddr_ff <= OFS_FILE_DATA &&
                         awaddr_ff[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rdata = rd_value;
            nxt_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
    end
    // ************************************************************
    // instruction sequencer and software registers
    // ************************************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_ext_en = ext_en_ff;
        nxt_instr = instr_ff;
        nxt_wreg = wreg_ff;
        nxt_status = status_ff;
        nxt_bank = bank_ff;
        nxt_base = base_ff;
        nxt_faddr = faddr_ff;
        nxt_illegal = illegal_ff;
        nxt_left = left_ff;
        nxt_dest = dest_ff;
        nxt_phys = phys_ff;
        nxt_operand = operand_ff;
        nxt_result = result_ff;
        mem_we = 1'b0;
        mem_waddr = faddr_ff;
        mem_wdata = wdata_ff[7:0];
        // software writes; instr, wreg, status and file data writes are dropped while an instruction runs
        if (do_write) begin
            unique case (awaddr_ff)
                OFS_CTRL: nxt_ext_en = wr_merged[CTRL_EXT_BIT];
                OFS_BANK: nxt_bank = wr_merged[3:0];
                OFS_INDEX_BASE: nxt_base = wr_merged[11:0];
                OFS_FILE_ADDR: nxt_faddr = wr_merged[11:0];
                OFS_INSTR: begin
                    if (!busy) begin
                        nxt_instr = wr_merged[15:0];
                        nxt_state = ST_Q1;
                    end
                end
                OFS_WREG: begin
                    if (!busy && wstrb_ff[0]) begin
                        nxt_wreg = wdata_ff[7:0];
                    end
                end
                OFS_STATUS: begin
                    if (!busy && wstrb_ff[0]) begin
                        nxt_status = wdata_ff[7:0];
                    end
                end
                OFS_FILE_DATA: begin
                    mem_we = !busy && wstrb_ff[0];
                end
                default: ;
            endcase
        end
        // one instruction cycle in four phases
        unique case (state_ff)
            ST_IDLE: ;
            ST_Q1: begin
                nxt_left = (instr_ff[OPC_MSB:OPC_LSB] ==
                            OPC_ROTATE_LEFT_PLAIN);
                // right rotate opcode match; any other code is
                // flagged and ends here with nothing touched
                nxt_illegal = !nxt_left && (instr_ff[OPC_MSB:OPC_LSB] !=
                                            OPC_ROTATE_RIGHT_VIA_CARRY);
                nxt_state = nxt_illegal ? ST_IDLE : ST_Q2;
                nxt_dest = instr_ff[DEST_BIT];
                nxt_phys = dec_phys;
            end
            ST_Q2: begin
                // read the addressed file register
                nxt_operand = file_mem[phys_ff];
                nxt_state = ST_Q3;
            end
            ST_Q3: begin
                nxt_result = rot_result;
                nxt_status[STAT_N_BIT] = rot_neg;
                nxt_status[STAT_Z_BIT] = rot_zero;
                // left passes carry through, right takes bit 0
                nxt_status[STAT_C_BIT] = rot_carry;
                nxt_state = ST_Q4;
            end
            ST_Q4: begin
                if (dest_ff) begin
                    mem_we = 1'b1;
                    mem_waddr = phys_ff;
                    mem_wdata = result_ff;
                end else begin
                    nxt_wreg = result_ff;
                end
                nxt_state = ST_IDLE;
            end
        endcase
    end
    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            w_full_ff <= 1'b0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
            state_ff <= ST_IDLE;
            ext_en_ff <= 1'b0;
            instr_ff <= RST_INSTR;
            wreg_ff <= RST_WREG;
            status_ff <= RST_STATUS;
            bank_ff <= RST_BANK;
            base_ff <= RST_INDEX_BASE;
            faddr_ff <= 12'h000;
            illegal_ff <= 1'b0;
            left_ff <= 1'b0;
            dest_ff <= 1'b0;
            phys_ff <= 12'h000;
            operand_ff <= 8'h00;
            result_ff <= 8'h00;
        end else begin
            aw_full_ff <= nxt_aw_full;
            awaddr_ff <= nxt_awaddr;
            w_full_ff <= nxt_w_full;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            state_ff <= nxt_state;
            ext_en_ff <= nxt_ext_en;
            instr_ff <= nxt_instr;
            wreg_ff <= nxt_wreg;
            status_ff <= nxt_status;
            bank_ff <= nxt_bank;
            base_ff <= nxt_base;
            faddr_ff <= nxt_faddr;
            illegal_ff <= nxt_illegal;
            left_ff <= nxt_left;
            dest_ff <= nxt_dest;
            phys_ff <= nxt_phys;
            operand_ff <= nxt_operand;
            result_ff <= nxt_result;
        end
    end
    // file memory has no reset; software loads it before use
    always_ff @(posedge aclk) begin
        if (mem_we) begin
            file_mem[mem_waddr] <= mem_wdata;
        end
    end
endmodule
`default_nettype wire

/* bru_pkg.sv */
// shared constants and types of the byte rotate unit
package bru_pkg;

    // ************************************************************
    // register map, byte addresses on the 32-bit bus
    // ************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_INSTR = 8'h04;
    localparam logic [7:0] OFS_WREG = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_BANK = 8'h10;
    localparam logic [7:0] OFS_INDEX_BASE = 8'h14;
    localparam logic [7:0] OFS_FILE_ADDR = 8'h18;
    localparam logic [7:0] OFS_FILE_DATA = 8'h1C;
    localparam logic [7:0] OFS_STATE = 8'h20;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CTRL_EXT_BIT = 0;
    localparam int STAT_C_BIT = 0;
    localparam int STAT_Z_BIT = 2;
    localparam int STAT_N_BIT = 4;
    localparam int STATE_BUSY_BIT = 0;
    localparam int STATE_ILL_BIT = 1;
    localparam int STATE_PHASE_LSB = 4;

    // ************************************************************
    // instruction word layout
    // ************************************************************
    localparam int OPC_MSB = 15;
    localparam int OPC_LSB = 10;
    localparam int DEST_BIT = 9;
    localparam int ACC_BIT = 8;
    localparam logic [5:0] OPC_ROTATE_LEFT_PLAIN = 6'h11;
    localparam logic [5:0] OPC_ROTATE_RIGHT_VIA_CARRY = 6'h0C;

    // ************************************************************
    // addressing
    // ************************************************************
    localparam logic [7:0] ACCESS_SPLIT = 8'h5F;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam int FILE_DEPTH = 4096;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_WREG = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [3:0] RST_BANK = 4'h0;
    localparam logic [11:0] RST_INDEX_BASE = 12'h000;
    localparam logic [15:0] RST_INSTR = 16'h0000;

    // ************************************************************
    // bus answers
    // ************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // instruction cycle phases
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_Q1,
        ST_Q2,
        ST_Q3,
        ST_Q4
    } bru_state_t;

endpackage

/* bru_rotate.sv */
// rotate datapath: left without carry, right through carry, flags
`timescale 1ns/1ps
`default_nettype none
module bru_rotate (
    input wire logic op_left,
    input wire logic [7:0] operand,
    input wire logic carry_in,
    output logic [7:0] result,
    output logic carry_out,
    output logic neg,
    output logic zero
);
    // ************************************************************
    // rotate and flags
    // ************************************************************
    always_comb begin
        if (op_left) begin
            // bit n to n+1, bit 7 to 0
            result = {operand[6:0], operand[7]};
            carry_out = carry_in;
        end else begin
            // old carry in top, bit 0 out
            result = {carry_in, operand[7:1]};
            carry_out = operand[0];
        end
        neg = result[7];
        zero = (result == 8'h00);
    end
endmodule
`default_nettype wire

/* bru_addr.sv */
// operand address resolution: access bank, banked and indexed modes
`timescale 1ns/1ps
`default_nettype none
module bru_addr (
    input wire logic acc_n,
    input wire logic [7:0] file_addr,
    input wire logic [3:0] bank_select_register,
    input wire logic ext_en,
    input wire logic [11:0] index_base,
    output logic [11:0] phys_addr,
    output logic indexed
);
    import bru_pkg::*;

    // ************************************************************
    // address decode
    // ************************************************************
    always_comb begin
        indexed = 1'b0;
        if (acc_n) begin
            phys_addr = {bank_select_register, file_addr};
        end else if (ext_en && file_addr <= ACCESS_SPLIT) begin
            indexed = 1'b1;
            phys_addr = index_base + {4'h0, file_addr};
        end else if (file_addr <= ACCESS_SPLIT) begin
            phys_addr = {ACCESS_LOW_BANK, file_addr};
        end else begin
            // access bank above ACCESS_SPLIT maps onto the top bank
            phys_addr = {ACCESS_HIGH_BANK, file_addr};
        end
    end
endmodule
`default_nettype wire

/* bru_top_props.sv */
// bus-side assertion checker for the byte rotate unit
`timescale 1ns/1ps
`default_nettype none
module bru_checker
    import bru_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ************************************************************
    // handshake properties
    // ************************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic wr_go;
    logic rd_go;
    // both write channels taken together, as the bench offers them
    assign wr_go = s_axi_awvalid && s_axi_awready &&
                   s_axi_wvalid && s_axi_wready;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    // the write lands one cycle after both halves are held; bvalid
    // is registered from that, so it is seen two edges later
    a_write_answer: assert property (wr_go |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_read_answer: assert property (rd_go |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_closes: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid) else $error("write answer stuck");
    a_read_closes: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid) else $error("read answer stuck");
    a_ready_blocked: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_unmapped_read: assert property (rd_go && s_axi_araddr > OFS_STATE |=>
        s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_state_readonly: assert property (wr_go && s_axi_awaddr == OFS_STATE |->
        ##2 s_axi_bresp == RESP_SLVERR) else $error("state write accepted");
    a_phase_range: assert property (
        rd_go && s_axi_araddr == OFS_STATE |=>
        s_axi_rdata[6:4] <= 3'h4 && s_axi_rdata[31:7] == 25'h0)
        else $error("phase out of range");
    c_instr: cover property (wr_go && s_axi_awaddr == OFS_INSTR);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    c_state: cover property (rd_go && s_axi_araddr == OFS_STATE);
endmodule
`default_nettype wire

/* byte_rotate_unit_bench.sv */
// self-checking bench of the byte rotate unit
`timescale 1ns/1ps
`default_nettype none
module byte_rotate_unit_bench;
    import bru_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    int bad_count = 0;
    int n_tests = 0;
    always #5 aclk = ~aclk;
    bru_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    // ************************************************************
    // bus tasks and expectations
    // ************************************************************
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // both write channels offered at once, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic put(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        check("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
    endtask
    task automatic peek(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check(what, d, exp);
    endtask
    // carry out above the rotated byte
    function automatic logic [8:0] rotate(input logic left,
                                          input logic [7:0] v, input logic c);
        return left ? {c, v[6:0], v[7]} : {v[0], c, v[7:1]};
    endfunction
    function automatic logic [11:0] phys_of(input logic a, input logic ext,
        input logic [7:0] f, input logic [3:0] bank, input logic [11:0] base);
        if (a) return {bank, f};
        if (f <= 8'h5F) return ext ? base + {4'h0, f} : {4'h0, f};
        return {4'hF, f};
    endfunction
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        logic [31:0] rn, rm, d;
        logic [1:0] r;
        logic [7:0] v, f, w, sb, sx;
        logic [7:0] cv [4] = '{8'h00, 8'h01, 8'h80, 8'hFE};
        logic [11:0] pa;
        logic [8:0] res;
        logic [5:0] op;
        logic left, dst, acc, ext, c;
        void'($urandom(51807));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        peek("wreg", OFS_WREG, 32'h0);
        peek("status", OFS_STATUS, 32'h0);
        peek("state", OFS_STATE, 32'h0);
        rd(8'h24, d, r);
        check("unmapped", {d[29:0], r}, {30'h0, RESP_SLVERR});
        wr(OFS_STATE, 32'h0, r);
        check("state write", {30'h0, r}, {30'h0, RESP_SLVERR});
        for (int i = 0; i < 48; i++) begin
            rn = $urandom();
            rm = $urandom();
            {v, f, c, ext, acc, dst, left} = {rn[31:16], rn[4:0]};
            w = rm[7:0];
            // corner operands first: zero result, carry wrap, sign
            if (i < 4) begin
                v = cv[i];
                left = ~i[0];
                c = i[1];
            end
            // addresses on both sides of the access split
            if (i >= 4 && i < 8) begin
                acc = 1'b0;
                ext = ~i[1];
                f = i[0] ? 8'h60 : 8'h5F;
            end
            sb = {rm[31:25], c};
            pa = phys_of(acc, ext, f, rn[11:8], rm[19:8]);
            put(OFS_CTRL, {31'h0, ext});
            put(OFS_BANK, {28'h0, rn[11:8]});
            put(OFS_INDEX_BASE, {20'h0, rm[19:8]});
            put(OFS_WREG, {24'h0, w});
            put(OFS_STATUS, {24'h0, sb});
            put(OFS_FILE_ADDR, {20'h0, pa});
            put(OFS_FILE_DATA, {24'h0, v});
            op = left ? OPC_ROTATE_LEFT_PLAIN : OPC_ROTATE_RIGHT_VIA_CARRY;
            put(OFS_INSTR, {16'h0, op, dst, acc, f});
            rd(OFS_STATE, d, r);
            check("busy", {31'h0, d[STATE_BUSY_BIT]}, 32'h1);
            do rd(OFS_STATE, d, r); while (d[STATE_BUSY_BIT] !== 1'b0);
            res = rotate(left, v, c);
            sx = sb;
            sx[STAT_C_BIT] = res[8];
            sx[STAT_Z_BIT] = res[7:0] == 8'h00;
            sx[STAT_N_BIT] = res[7];
            peek("status", OFS_STATUS, {24'h0, sx});
            peek("wreg", OFS_WREG, {24'h0, dst ? w : res[7:0]});
            peek("file", OFS_FILE_DATA, {24'h0, dst ? res[7:0] : v});
        end
        // an unknown opcode must leave the working register alone
        put(OFS_WREG, 32'h5A);
        put(OFS_INSTR, {16'h0, 6'h3F, 10'h0});
        do rd(OFS_STATE, d, r); while (d[STATE_BUSY_BIT] !== 1'b0);
        check("illegal", {31'h0, d[STATE_ILL_BIT]}, 32'h1);
        peek("wreg", OFS_WREG, 32'h5A);
        close_out();
    end
    // the run needs under two thousand cycles; twenty times that means a hang
    initial begin
        #400000;
        bad_count++;
        close_out();
    end
endmodule
bind bru_top bru_checker chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
`default_nettype wire
